// File: core/hpsl_pkg.sv
// Package for the host port address and strobe logic.
// Assumes one clock domain; every user names items as hpsl_pkg::name.
package hpsl_pkg;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned WORD_W      = 32;
    localparam int unsigned FIFO_DEPTH  = 8;

    localparam logic [1:0] ACC_CTRL     = 2'h0;
    localparam logic [1:0] ACC_DATA_INC = 2'h1;
    localparam logic [1:0] ACC_ADDR     = 2'h2;
    localparam logic [1:0] ACC_DATA     = 2'h3;

    // Control register fields
    localparam int unsigned CTL_HWORD_BIT = 0;
    localparam int unsigned CTL_SPLIT_BIT = 1;
    localparam int unsigned CTL_SEL_BIT   = 2;
    localparam int unsigned CTL_HWSTAT_BIT = 8;
    localparam logic [2:0]  CTL_RESET     = 3'h0;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP  = 32'h0000_0004;

    // Captured host controls
    typedef struct packed {
        logic [1:0] acc;
        logic       rd;
    } hpsl_ctl_t;

    // Memory request toward the DMA path
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } hpsl_req_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_DECO  = 5'h02,
        ST_RDREQ = 5'h04,
        ST_RDWT  = 5'h08,
        ST_DONE  = 5'h10
    } hpsl_state_t;
endpackage : hpsl_pkg

// File: core/hpsl_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
module hpsl_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rp_r];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : hpsl_fifo

// File: core/hpsl_port.sv
// Host port slave: strobe/select combining, control capture, address registers,
// data register and DMA request/response path.
// Assumes host pins already synchronous to clk_sys; DMA memory side is a
// valid/ready request port with a read response strobe.
//
// Operation
// RL1 - Split mode set: read and write address registers are independent to host.
// RL2 - Split mode address access hits read reg when select is 1, else write reg.
// RL3 - Address select bit is ignored in single address mode.
// RL4 - DMA reads use read address, writes use write address, regardless of select.
// RL5 - Split mode autoincrement advances only the direction's address register.
// RL6 - Address register increments only after it was used for the access.
// RL7 - Host programs control, then address, then data register.
// RL8 - Host drives access type and direction lines every step.
// RL9 - Ready deasserts while internal resources are busy.
// RL10 - Controls captured on internal strobe falling edge, then access starts.
// RL11 - Read fetches via read address into data reg; ready low marks valid.
// RL12 - Host captures read data then releases strobe.
// RL13 - Host waits ready low; write data captured on strobe rising edge.
// RL14 - Write data goes to memory at write address register.
// RL15 - Internal strobe from select and both strobes; select high ignores strobes.
// RL16 - Ready is forced low whenever select is high.
// RL17 - Host may tie select to one data strobe.
// RL18 - Using select alone as strobe with static data strobes is discouraged.
// RL19 - Single strobe host ties unused input high or low per polarity.
// RL20 - Separate read/write strobes go to each input; direction from address line.
// RL21 - Access type: 00 control, 01 data inc, 10 address, 11 data.
// RL22 - Direction high for read, low for write, sampled at strobe fall.
// RL23 - Single mode address write loads both; autoincrement advances both.
// RL24 - Internal strobe active when select low and strobes differ.
`timescale 1ns/1ps
module hpsl_port #(
    parameter int unsigned DW    = hpsl_pkg::DATA_W,
    parameter int unsigned AW    = hpsl_pkg::ADDR_W,
    parameter int unsigned DEPTH = hpsl_pkg::FIFO_DEPTH
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    // Host pins
    input  wire logic          port_select_n,
    input  wire logic          data_strobe_one,
    input  wire logic          data_strobe_two,
    input  wire logic [1:0]    access_type_select,
    input  wire logic          read_write_select,
    input  wire logic [DW-1:0] host_data_bus_in,
    output logic      [DW-1:0] host_data_bus_out,
    output logic               host_data_bus_oe_n,
    output logic               host_ready,
    // DMA memory side
    output logic               mem_req_valid,
    input  wire logic          mem_req_ready,
    output logic               mem_req_wr,
    output logic      [AW-1:0] mem_req_addr,
    output logic      [DW-1:0] mem_req_data,
    input  wire logic          mem_rsp_valid,
    input  wire logic [DW-1:0] mem_rsp_data,
    // Status
    output logic               halfword_order,
    output logic               split_address_mode,
    output logic               address_reg_select,
    output logic      [AW-1:0] read_address_reg,
    output logic      [AW-1:0] write_address_reg
);
    localparam int unsigned QW = 1 + AW + DW;

    hpsl_pkg::hpsl_state_t state_r;
    hpsl_pkg::hpsl_state_t state_nxt;
    hpsl_pkg::hpsl_ctl_t   ctl_r;
    hpsl_pkg::hpsl_req_t   wreq;
    hpsl_pkg::hpsl_req_t   rreq;
    hpsl_pkg::hpsl_req_t   fifo_in;
    hpsl_pkg::hpsl_req_t   fifo_out;

    logic [2:0]    cfg_r;
    logic [AW-1:0] rd_addr_r;
    logic [AW-1:0] wr_addr_r;
    logic [DW-1:0] rdout_r;
    logic          strobe_r;
    logic          rd_busy;
    logic          internal_strobe;
    logic          strobe_fall;
    logic          strobe_rise;
    logic          split;
    logic          sel_rd;
    logic          acc_addr;
    logic          acc_data;
    logic          acc_inc;
    logic          wr_push;
    logic          rd_push;
    logic          fifo_in_valid;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic          dev_ready;
    logic [DW-1:0] addr_rd_view;
    logic [DW-1:0] ctl_view;

    // Active low, select gates both strobes; XOR handles either polarity
    assign internal_strobe = ~(~port_select_n & (data_strobe_one ^ data_strobe_two)); // RL15 RL24
    assign strobe_fall     = strobe_r & ~internal_strobe; // RL10
    assign strobe_rise     = ~strobe_r & internal_strobe; // RL13

    assign split    = cfg_r[hpsl_pkg::CTL_SPLIT_BIT]; // RL1
    assign sel_rd   = split & cfg_r[hpsl_pkg::CTL_SEL_BIT]; // RL2 RL3
    assign acc_addr = (ctl_r.acc == hpsl_pkg::ACC_ADDR); // RL21
    assign acc_inc  = (ctl_r.acc == hpsl_pkg::ACC_DATA_INC); // RL21
    assign acc_data = acc_inc | (ctl_r.acc == hpsl_pkg::ACC_DATA); // RL21

    // Only low address half is carried on the 16-bit bus in this block
    assign addr_rd_view = split ? (sel_rd ? rd_addr_r[DW-1:0] : wr_addr_r[DW-1:0])
                                : rd_addr_r[DW-1:0]; // RL2 RL3
    assign ctl_view     = DW'({cfg_r[hpsl_pkg::CTL_HWORD_BIT], 5'h00, cfg_r});

    // Write data goes from the host data bus toward memory at the write address
    assign wr_push = strobe_rise & ~ctl_r.rd & acc_data & (state_r == hpsl_pkg::ST_DONE); // RL13
    assign rd_push = (state_r == hpsl_pkg::ST_RDREQ);
    assign wreq    = '{wr: 1'b1, addr: wr_addr_r, data: host_data_bus_in}; // RL4 RL14
    assign rreq    = '{wr: 1'b0, addr: rd_addr_r, data: '0}; // RL4 RL11
    assign fifo_in       = rd_push ? rreq : wreq;
    assign fifo_in_valid = wr_push | rd_push;
    assign rd_busy       = (state_r == hpsl_pkg::ST_RDREQ) | (state_r == hpsl_pkg::ST_RDWT);

    // A full FIFO or an outstanding fetch holds the host off
    assign dev_ready  = (state_r == hpsl_pkg::ST_DONE) & ~rd_busy & fifo_in_ready; // RL9
    assign host_ready = port_select_n ? 1'b0 : ~dev_ready; // RL16 RL11
    assign host_data_bus_out  = rdout_r;
    assign host_data_bus_oe_n = ~(ctl_r.rd & ~internal_strobe & (state_r == hpsl_pkg::ST_DONE));

    assign mem_req_wr   = fifo_out.wr;
    assign mem_req_addr = fifo_out.addr;
    assign mem_req_data = fifo_out.data;
    assign mem_req_valid = fifo_out_valid;

    assign halfword_order     = cfg_r[hpsl_pkg::CTL_HWORD_BIT];
    assign split_address_mode = cfg_r[hpsl_pkg::CTL_SPLIT_BIT];
    assign address_reg_select = cfg_r[hpsl_pkg::CTL_SEL_BIT];
    assign read_address_reg   = rd_addr_r;
    assign write_address_reg  = wr_addr_r;

    hpsl_fifo #(
        .WIDTH (QW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (mem_req_ready),
        .out_data  (fifo_out)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            hpsl_pkg::ST_IDLE: begin
                if (strobe_fall) begin
                    state_nxt = hpsl_pkg::ST_DECO; // RL10
                end
            end
            hpsl_pkg::ST_DECO: begin
                if (acc_data && ctl_r.rd) begin
                    state_nxt = hpsl_pkg::ST_RDREQ; // RL11
                end else begin
                    state_nxt = hpsl_pkg::ST_DONE;
                end
            end
            hpsl_pkg::ST_RDREQ: begin
                if (fifo_in_ready) begin
                    state_nxt = hpsl_pkg::ST_RDWT;
                end
            end
            hpsl_pkg::ST_RDWT: begin
                if (mem_rsp_valid) begin
                    state_nxt = hpsl_pkg::ST_DONE;
                end
            end
            hpsl_pkg::ST_DONE: begin
                if (strobe_rise) begin
                    state_nxt = hpsl_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = hpsl_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r  <= hpsl_pkg::ST_IDLE;
            strobe_r <= 1'b1;
            ctl_r    <= '0;
        end else begin
            state_r  <= state_nxt;
            strobe_r <= internal_strobe;
            if (strobe_fall) begin
                ctl_r <= '{acc: access_type_select, rd: read_write_select}; // RL10
            end
        end
    end

    // Control and address register writes land on the strobe rising edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_r <= hpsl_pkg::CTL_RESET;
        end else if (strobe_rise && !ctl_r.rd && ctl_r.acc == hpsl_pkg::ACC_CTRL) begin
            cfg_r <= host_data_bus_in[2:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_addr_r <= hpsl_pkg::ADDR_RESET;
        end else if (strobe_rise && !ctl_r.rd && acc_addr && (!split || sel_rd)) begin
            rd_addr_r <= AW'(host_data_bus_in); // RL2 RL23
        end else if (state_r == hpsl_pkg::ST_RDWT && mem_rsp_valid && acc_inc) begin
            rd_addr_r <= rd_addr_r + hpsl_pkg::ADDR_STEP; // RL5 RL6
        end else if (wr_push && acc_inc && !split) begin
            rd_addr_r <= rd_addr_r + hpsl_pkg::ADDR_STEP; // RL23
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_addr_r <= hpsl_pkg::ADDR_RESET;
        end else if (strobe_rise && !ctl_r.rd && acc_addr && (!split || !sel_rd)) begin
            wr_addr_r <= AW'(host_data_bus_in); // RL2 RL23
        end else if (wr_push && acc_inc) begin
            wr_addr_r <= wr_addr_r + hpsl_pkg::ADDR_STEP; // RL5 RL6
        end else if (state_r == hpsl_pkg::ST_RDWT && mem_rsp_valid && acc_inc && !split) begin
            wr_addr_r <= wr_addr_r + hpsl_pkg::ADDR_STEP; // RL23
        end
    end

    // Read view register: picks the source named by the captured controls
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdout_r <= '0;
        end else if (state_r == hpsl_pkg::ST_DECO && ctl_r.acc == hpsl_pkg::ACC_CTRL) begin
            rdout_r <= ctl_view;
        end else if (state_r == hpsl_pkg::ST_DECO && acc_addr) begin
            rdout_r <= addr_rd_view;
        end else if (state_r == hpsl_pkg::ST_RDWT && mem_rsp_valid) begin
            rdout_r <= mem_rsp_data; // RL11
        end
    end
endmodule : hpsl_port

// File: tb/hpsl_props.sv
// Checker for strobe, ready and address register relations of the host port.
// Sees only hpsl_port ports; bound to every instance of it.
`timescale 1ns/1ps
module hpsl_props (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        port_select_n,
    input wire logic        data_strobe_one,
    input wire logic        data_strobe_two,
    input wire logic        host_data_bus_oe_n,
    input wire logic        host_ready,
    input wire logic        mem_req_valid,
    input wire logic        mem_req_wr,
    input wire logic [31:0] mem_req_addr,
    input wire logic        split_address_mode,
    input wire logic [31:0] read_address_reg,
    input wire logic [31:0] write_address_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire strb = !port_select_n && (data_strobe_one != data_strobe_two);
    sequence s_fall_seen;
        $rose(strb);
    endsequence
    sequence s_wait_two;
        host_ready [*2];
    endsequence
    a_ready_desel: assert property (port_select_n |-> !host_ready)
        else $error("ready high while deselected");
    a_ready_wait: assert property (s_fall_seen |-> s_wait_two)
        else $error("ready low too early after strobe fall");
    a_ready_hold: assert property (strb && !host_ready |=> !strb || !host_ready)
        else $error("ready dropped before strobe rise");
    a_oe_drive: assert property (!host_data_bus_oe_n |-> strb && !host_ready)
        else $error("bus driven outside a ready strobe");
    a_split_indep: assert property (split_address_mode && $past(split_address_mode) |->
        !($changed(read_address_reg) && $changed(write_address_reg)))
        else $error("both address registers moved in split mode");
    a_dma_rd_addr: assert property (mem_req_valid && !mem_req_wr |->
        mem_req_addr == read_address_reg)
        else $error("read request not at read address");
    // Single mode also steps the write address on a read response, mid-strobe
    a_wr_addr_rise: assert property (split_address_mode && $changed(write_address_reg) |->
        !strb || !$past(strb))
        else $error("write address moved during strobe");
    a_ctl_rise: assert property ($changed(split_address_mode) |-> !strb || !$past(strb))
        else $error("control moved during strobe");
endmodule : hpsl_props

bind hpsl_port hpsl_props hpsl_props_inst (.clk_sys, .rst_n, .port_select_n,
    .data_strobe_one, .data_strobe_two, .host_data_bus_oe_n, .host_ready, .mem_req_valid,
    .mem_req_wr, .mem_req_addr, .split_address_mode, .read_address_reg, .write_address_reg);

// File: tb/hpsl_mem_model.sv
// Memory on the DMA side of the host port; can stall requests on demand.
// Assumes one request at a time is answered; read answers come 3 cycles late.
`timescale 1ns/1ps
module hpsl_mem_model (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        stall,
    input wire logic        mem_req_valid,
    output logic            mem_req_ready,
    input wire logic        mem_req_wr,
    input wire logic [31:0] mem_req_addr,
    input wire logic [15:0] mem_req_data,
    output logic            mem_rsp_valid,
    output logic     [15:0] mem_rsp_data
);
    logic [15:0] mem [logic [31:0]];
    logic [31:0] rd_addr;
    int          pend;
    initial mem_rsp_data = 16'h0;
    always @(posedge clk_sys) begin
        mem_rsp_valid <= 1'b0;
        mem_req_ready <= rst_n && !stall;
        // Released response lines toggle so stale data never looks valid
        mem_rsp_data <= ~mem_rsp_data;
        if (!rst_n) begin
            pend <= 0;
        end else begin
            if (mem_req_valid && mem_req_ready && mem_req_wr) mem[mem_req_addr] = mem_req_data;
            if (mem_req_valid && mem_req_ready && !mem_req_wr) begin
                rd_addr <= mem_req_addr;
                pend <= 3;
            end else if (pend > 0) begin
                pend <= pend - 1;
            end
            if (pend == 1) begin
                mem_rsp_valid <= 1'b1;
                mem_rsp_data <= mem.exists(rd_addr) ? mem[rd_addr] : 16'h0;
            end
        end
    end
endmodule : hpsl_mem_model

// File: tb/test_host_port_address_strobe_logic.sv
// Testbench for the host port: host cycles driven on falling edges.
// Assumes hpsl_port and hpsl_mem_model; the checker is bound separately.
`timescale 1ns/1ps
module test_host_port_address_strobe_logic;
    logic clk_sys = 0, rst_n = 0, cs_n = 0, ds1 = 1, ds2 = 1, rw = 0, stall = 0;
    logic [1:0] acc = 2'h0;
    logic [15:0] din = 16'h0, dout, rdat, rsp_d, mreq_d;
    logic oe_n, rdy, mreq_v, mreq_r, mreq_w, rsp_v, hwo, split, sel;
    logic [31:0] mreq_a, ra, wa;
    int err_count = 0, checks = 0, waits;
    always #20 clk_sys = ~clk_sys;
    hpsl_port hpsl_port_inst (.clk_sys, .rst_n, .port_select_n(cs_n), .data_strobe_one(ds1),
        .data_strobe_two(ds2), .access_type_select(acc), .read_write_select(rw),
        .host_data_bus_in(din), .host_data_bus_out(dout), .host_data_bus_oe_n(oe_n),
        .host_ready(rdy), .mem_req_valid(mreq_v), .mem_req_ready(mreq_r), .mem_req_wr(mreq_w),
        .mem_req_addr(mreq_a), .mem_req_data(mreq_d), .mem_rsp_valid(rsp_v),
        .mem_rsp_data(rsp_d), .halfword_order(hwo), .split_address_mode(split),
        .address_reg_select(sel), .read_address_reg(ra), .write_address_reg(wa));
    hpsl_mem_model hpsl_mem_model_inst (.clk_sys, .rst_n, .stall, .mem_req_valid(mreq_v),
        .mem_req_ready(mreq_r), .mem_req_wr(mreq_w), .mem_req_addr(mreq_a),
        .mem_req_data(mreq_d), .mem_rsp_valid(rsp_v), .mem_rsp_data(rsp_d));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Mode 0: active-low strobe, 1: active-high strobe, 2: select tied to strobe,
    // 3: separate active-low read (one) and write (two) strobes
    task automatic cyc(input logic [1:0] a, input logic r, input logic [15:0] d,
                       input int mode = 0);
        waits = 0;
        @(negedge clk_sys);
        {acc, rw, din} = {a, r, d};
        cs_n = 1'b0;
        ds1 = (mode == 1) || (mode == 3 && !r);
        ds2 = (mode != 1) && !(mode == 3 && !r);
        do begin
            @(negedge clk_sys);
            waits++;
        end while (rdy !== 1'b0 && waits < 400);
        chk("ready", 1'b0, rdy);
        rdat = dout;
        if (r) chk("bus enable", 1'b0, oe_n);
        @(negedge clk_sys);
        ds1 = (mode != 1);
        ds2 = (mode != 1);
        cs_n = (mode == 2);
        repeat (3) @(negedge clk_sys);
    endtask : cyc
    task automatic t_single;
        cyc(hpsl_pkg::ACC_CTRL, 0, 16'h0004);
        cyc(hpsl_pkg::ACC_ADDR, 0, 16'h0100);
        chk("rd addr", 32'h100, ra);
        chk("wr addr", 32'h100, wa);
        cyc(hpsl_pkg::ACC_DATA_INC, 0, 16'h1234);
        chk("mem", 16'h1234, hpsl_mem_model_inst.mem[32'h100]);
        chk("rd addr", 32'h104, ra);
        chk("wr addr", 32'h104, wa);
        hpsl_mem_model_inst.mem[32'h104] = 16'h7e57;
        cyc(hpsl_pkg::ACC_DATA_INC, 1, 16'h0);
        chk("rd data", 16'h7e57, rdat);
        chk("rd addr", 32'h108, ra);
        chk("wr addr", 32'h108, wa);
        $display("test single done");
    endtask : t_single
    task automatic t_split;
        cyc(hpsl_pkg::ACC_CTRL, 0, 16'h0006);
        chk("ctl bits", 3'h6, {sel, split, hwo});
        cyc(hpsl_pkg::ACC_ADDR, 0, 16'h0200);
        chk("rd addr", 32'h200, ra);
        chk("wr addr", 32'h108, wa);
        cyc(hpsl_pkg::ACC_CTRL, 0, 16'h0002);
        cyc(hpsl_pkg::ACC_ADDR, 0, 16'h0300);
        chk("wr addr", 32'h300, wa);
        chk("rd addr", 32'h200, ra);
        cyc(hpsl_pkg::ACC_ADDR, 1, 16'h0);
        chk("addr view", 16'h0300, rdat);
        hpsl_mem_model_inst.mem[32'h200] = 16'h5a5a;
        hpsl_mem_model_inst.mem[32'h204] = 16'ha5a5;
        cyc(hpsl_pkg::ACC_DATA_INC, 1, 16'h0);
        chk("rd data", 16'h5a5a, rdat);
        chk("rd addr", 32'h204, ra);
        chk("wr addr", 32'h300, wa);
        cyc(hpsl_pkg::ACC_DATA_INC, 0, 16'hbeef);
        chk("mem", 16'hbeef, hpsl_mem_model_inst.mem[32'h300]);
        chk("wr addr", 32'h304, wa);
        chk("rd addr", 32'h204, ra);
        cyc(hpsl_pkg::ACC_DATA, 0, 16'hc0de);
        chk("mem", 16'hc0de, hpsl_mem_model_inst.mem[32'h304]);
        chk("wr addr", 32'h304, wa);
        cyc(hpsl_pkg::ACC_DATA, 1, 16'h0);
        chk("rd data", 16'ha5a5, rdat);
        chk("rd addr", 32'h204, ra);
        cyc(hpsl_pkg::ACC_CTRL, 0, 16'h0007);
        cyc(hpsl_pkg::ACC_CTRL, 1, 16'h0);
        chk("ctrl", 16'h0107, rdat);
        $display("test split done");
    endtask : t_split
    task automatic t_strobes;
        cyc(hpsl_pkg::ACC_CTRL, 0, 16'h0006, 1);
        {cs_n, acc, rw, din} = {1'b1, hpsl_pkg::ACC_ADDR, 1'b0, 16'hffff};
        repeat (4) begin
            @(negedge clk_sys);
            ds1 = ~ds1;
            chk("desel ready", 1'b0, rdy);
        end
        {cs_n, ds1, ds2} = 3'h0;
        repeat (6) @(negedge clk_sys);
        chk("idle ready", 1'b1, rdy);
        chk("rd addr", 32'h204, ra);
        ds1 = 1'b1;
        ds2 = 1'b1;
        cyc(hpsl_pkg::ACC_ADDR, 0, 16'h0400, 2);
        chk("rd addr", 32'h400, ra);
        cyc(hpsl_pkg::ACC_ADDR, 0, 16'h0500, 1);
        chk("rd addr", 32'h500, ra);
        cyc(hpsl_pkg::ACC_ADDR, 0, 16'h0700, 3);
        chk("rd addr", 32'h700, ra);
        cyc(hpsl_pkg::ACC_ADDR, 1, 16'h0, 3);
        chk("addr view", 16'h0700, rdat);
        cs_n = 1'b0;
        ds1 = 1'b1;
        ds2 = 1'b1;
        $display("test strobes done");
    endtask : t_strobes
    task automatic t_fifo;
        cyc(hpsl_pkg::ACC_CTRL, 0, 16'h0002);
        cyc(hpsl_pkg::ACC_ADDR, 0, 16'h0600);
        stall = 1'b1;
        for (int i = 0; i < 8; i++) cyc(hpsl_pkg::ACC_DATA_INC, 0, 16'(i));
        fork
            begin
                repeat (60) @(negedge clk_sys);
                stall = 1'b0;
            end
        join_none
        cyc(hpsl_pkg::ACC_DATA_INC, 0, 16'h0008);
        chk("full wait", 1'b1, waits >= 50);
        repeat (30) @(negedge clk_sys);
        for (int i = 0; i < 9; i++)
            chk("mem", 16'(i), hpsl_mem_model_inst.mem[32'h600 + 32'(4 * i)]);
        chk("wr addr", 32'h624, wa);
        $display("test fifo done");
    endtask : t_fifo
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        t_single();
        t_split();
        t_strobes();
        t_fifo();
        wrap_up();
    end
endmodule : test_host_port_address_strobe_logic
